/* File: core/rlc_pkg.sv */
/*
 * Constants, types and shared decoding for the remote alias and link
 * configuration block. Assumes 8-bit register addresses and data from the
 * serial control bus slave that sits in front of this block.
 */
package rlc_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_REMOTE_ALIAS_FOUR = 8'h7a;
  localparam logic [7:0] ADDR_REMOTE_ALIAS_FIVE = 8'h7b;
  localparam logic [7:0] ADDR_REMOTE_ALIAS_SIX = 8'h7c;
  localparam logic [7:0] ADDR_REMOTE_ALIAS_SEVEN = 8'h7d;
  localparam logic [7:0] ADDR_LINK_SECURITY_CONFIG = 8'hc2;

  // ************************************************************
  // field layout and reset values
  // ************************************************************
  localparam logic [7:0] ALIAS_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h80;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hba; // bits 6, 2, 0 reserved
  localparam int CFG_ENH_BIT = 7;
  localparam int CFG_RPT_BIT = 5;
  localparam int CFG_ENC_LSB = 3;
  localparam int CFG_QUAL_BIT = 1;
  localparam int ALIAS_W = 7;
  localparam int SLOTS = 4;
  localparam logic [4:0] FRAME_CHECK_PERIOD = 5'h10; // every 16th frame
  localparam logic [3:0] FRAME_CHECK_LAST = 4'(FRAME_CHECK_PERIOD - 5'h01);

  // ************************************************************
  // enumerations
  // ************************************************************
  typedef enum logic [1:0] {
    ENC_AUTHENTICATED = 2'h0,
    ENC_REG_CONTROL = 2'h1,
    ENC_ALWAYS = 2'h2,
    ENC_PER_FRAME_INBAND = 2'h3
  } rlc_enc_e;

  typedef enum logic [1:0] {
    PH_STRAP = 2'h0,
    PH_RUN = 2'h1
  } rlc_phase_e;

  // alias slot decode: bit 2 = hit, bits 1:0 = slot (used for reads and writes)
  function automatic logic [2:0] alias_slot(input logic [7:0] addr);
    logic [2:0] r;
    r = 3'h0;
    if (addr >= ADDR_REMOTE_ALIAS_FOUR && addr <= ADDR_REMOTE_ALIAS_SEVEN) begin
      r = {1'b1, 2'(addr - ADDR_REMOTE_ALIAS_FOUR)};
    end
    return r;
  endfunction
endpackage

/* File: core/rlc_alias_if.sv */
/*
 * Bundle between the configuration top and the alias store.
 * Assumes both ends share mclk.
 */
interface rlc_alias_if;
  logic wr_en;
  logic rd_en;
  logic [2:0] idx; // {port, slot}
  logic [6:0] wdata;
  logic [6:0] rdata;
  logic look_en;
  logic look_port;
  logic [6:0] look_addr;
  logic [3:0] hit;
  logic hit_valid;
  logic hit_port;

  modport ctrl (output wr_en, rd_en, idx, wdata, look_en, look_port, look_addr,
                input rdata, hit, hit_valid, hit_port);
  modport store (input wr_en, rd_en, idx, wdata, look_en, look_port, look_addr,
                 output rdata, hit, hit_valid, hit_port);
endinterface

/* File: core/rlc_alias_store.sv */
/*
 * Alias table for two link ports, four slots each, with registered read
 * data and a registered parallel lookup. Assumes one access per cycle.
 */
module rlc_alias_store
  import rlc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  rlc_alias_if.store bus
);
  typedef struct packed {
    logic [7:0][6:0] table_q;
    logic [6:0] rdata;
    logic [3:0] hit;
    logic hit_valid;
    logic hit_port;
  } rlc_store_s;

  rlc_store_s st;
  rlc_store_s next_st;

  // ************************************************************
  // write, read and lookup
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.hit_valid = bus.look_en;
    if (bus.wr_en) begin
      next_st.table_q[bus.idx] = bus.wdata;
    end
    if (bus.rd_en) begin
      next_st.rdata = st.table_q[bus.idx];
    end
    // zero alias never matches, so a cleared slot forwards nothing
    for (int i = 0; i < SLOTS; i++) begin
      next_st.hit[i] = bus.look_en && st.table_q[{bus.look_port, 2'(i)}] != 7'h00
                       && st.table_q[{bus.look_port, 2'(i)}] == bus.look_addr;
    end
    next_st.hit_port = bus.look_port;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.rdata = st.rdata;
  assign bus.hit = st.hit;
  assign bus.hit_valid = st.hit_valid;
  assign bus.hit_port = st.hit_port;
endmodule

/* File: core/rlc_link_check.sv */
/*
 * Frame counter that compares the cipher check value once every sixteenth
 * frame while enhanced checking is on. Assumes frame_start is one cycle.
 */
module rlc_link_check
  import rlc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic frame_start,
  input wire logic [7:0] local_value,
  input wire logic [7:0] remote_value,
  output logic check_pulse,
  output logic check_fail
);
  typedef struct packed {
    logic [3:0] frames;
    logic check_pulse;
    logic check_fail;
  } rlc_check_s;

  rlc_check_s st;
  rlc_check_s next_st;

  // ************************************************************
  // frame count and compare
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.check_pulse = 1'b0;
    if (!enable) begin
      next_st.frames = 4'h0; // restart the cadence when checking is re-enabled
    end else if (frame_start) begin
      next_st.frames = st.frames + 4'h1;
      if (st.frames == FRAME_CHECK_LAST) begin
        next_st.check_pulse = 1'b1;
        next_st.check_fail = local_value != remote_value;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign check_pulse = st.check_pulse;
  assign check_fail = st.check_fail;
endmodule

/* File: core/rlc_top.sv */
/*
 * Remote alias registers 4..7 and the link security configuration
 * register, with address translation, receiver-detect qualification and
 * periodic link verification. Assumes an 8-bit register port from the
 * serial control bus slave, synchronous inputs and one clock.
 */
// Notes on behaviour
// - A transaction addressed to a programmed 7-bit alias is redirected to the paired remote slave address.
// - An alias of zero disables its slot, so nothing is remapped or forwarded for it.
// - With the second port selected, alias register accesses use the second port's table.
// - Enhanced link checking compares the cipher check value every sixteenth frame, and never when off.
// - The configuration register reads 0x80 after reset with the repeater strap clear, and 0x98 with it set.
// - Configuration bit 5 turns repeater mode on or off.
// - At power-up the policy becomes 11 with the repeater strap set and 00 otherwise.
// - With the qualify bit clear, receiver-detect is raised as soon as a receiver is detected.
// - A remapped transaction is forwarded over the control channel with the paired remote slave ID.
// - The receiver-detect interrupt reaches the controller only with its enable and the global enable set.
module rlc_top
  import rlc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic repeater_strap,
  input wire logic second_port_select,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic xlat_req,
  input wire logic [6:0] xlat_addr,
  input wire logic [7:0][6:0] slave_id_table,
  output logic fwd_valid,
  output logic [6:0] fwd_addr,
  output logic [1:0] fwd_slot,
  output logic fwd_port,
  output logic xlat_reject,
  input wire logic frame_start,
  input wire logic [7:0] cipher_check_value,
  input wire logic [7:0] remote_check_value,
  output logic link_check_strobe,
  output logic link_check_fail,
  output logic enhanced_link_check_en,
  output logic repeater_enable,
  output logic [1:0] enc_mode,
  output logic enc_per_frame_inband,
  output logic receiver_detect_qualify,
  input wire logic rx_detected,
  input wire logic rx_lock,
  input wire logic receiver_detect_irq_en,
  input wire logic global_irq_en,
  output logic rxdet_event,
  output logic rxdet_irq
);
  typedef struct packed {
    rlc_phase_e phase;
    logic [7:0] cfg;
    logic rd_pend;
    logic rd_alias;
    logic [7:0] rd_cfg_val;
    logic [7:0] rdata;
    logic rvalid;
    logic fwd_valid;
    logic [6:0] fwd_addr;
    logic [1:0] fwd_slot;
    logic fwd_port;
    logic xlat_reject;
    logic det_q;
    logic rxdet_event;
    logic rxdet_irq;
  } rlc_top_s;

  rlc_top_s st;
  rlc_top_s next_st;

  rlc_alias_if alias_bus ();

  logic [2:0] wr_slot;
  logic [2:0] rd_slot;
  logic det_now;
  logic [1:0] hit_slot;

  // ************************************************************
  // alias store
  // ************************************************************
  rlc_alias_store u_store (
    .mclk(mclk),
    .rstn(rstn),
    .bus(alias_bus.store)
  );

  // accesses pick the port table from the live select input
  assign wr_slot = alias_slot(reg_addr);
  assign rd_slot = alias_slot(reg_addr);
  assign alias_bus.wr_en = reg_wr && wr_slot[2];
  assign alias_bus.rd_en = reg_rd && rd_slot[2];
  assign alias_bus.idx = {second_port_select, reg_addr == ADDR_REMOTE_ALIAS_FOUR ? 2'h0 : rd_slot[1:0]};
  assign alias_bus.wdata = reg_wdata[7:1]; // bit 0 reserved, dropped on write
  assign alias_bus.look_en = xlat_req;
  assign alias_bus.look_port = second_port_select;
  assign alias_bus.look_addr = xlat_addr;

  // ************************************************************
  // link verification cadence
  // ************************************************************
  rlc_link_check u_check (
    .mclk(mclk),
    .rstn(rstn),
    .enable(st.cfg[CFG_ENH_BIT]),
    .frame_start(frame_start),
    .local_value(cipher_check_value),
    .remote_value(remote_check_value),
    .check_pulse(link_check_strobe),
    .check_fail(link_check_fail)
  );

  // receiver-detect condition, with lock required when qualified
  assign det_now = rx_detected && (!st.cfg[CFG_QUAL_BIT] || rx_lock);

  // lowest matching slot wins if software programmed the same alias twice
  always_comb begin
    hit_slot = 2'h0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (alias_bus.hit[i]) begin
        hit_slot = 2'(i);
      end
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.fwd_valid = 1'b0;
    next_st.xlat_reject = 1'b0;
    next_st.rxdet_event = 1'b0;
    next_st.rxdet_irq = 1'b0;

    // strap is sampled on the first edge after reset release, never inside reset
    unique case (st.phase)
      PH_STRAP: begin
        next_st.phase = PH_RUN;
        next_st.cfg[CFG_ENC_LSB +: 2] = repeater_strap ? ENC_PER_FRAME_INBAND : ENC_AUTHENTICATED;
      end
      PH_RUN: begin
        if (reg_wr && reg_addr == ADDR_LINK_SECURITY_CONFIG) begin
          next_st.cfg = reg_wdata & CFG_WRITE_MASK;
        end
      end
    endcase

    // read pipeline: request, store read, output
    next_st.rd_pend = reg_rd;
    next_st.rd_alias = rd_slot[2];
    next_st.rd_cfg_val = reg_addr == ADDR_LINK_SECURITY_CONFIG ? st.cfg : 8'h00; // unmapped reads 0
    if (st.rd_pend) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = st.rd_alias ? {alias_bus.rdata, 1'b0} : st.rd_cfg_val;
    end

    // translation result one cycle after the lookup
    if (alias_bus.hit_valid) begin
      if (alias_bus.hit != 4'h0) begin
        next_st.fwd_valid = 1'b1;
        next_st.fwd_addr = slave_id_table[{alias_bus.hit_port, hit_slot}];
        next_st.fwd_slot = hit_slot;
        next_st.fwd_port = alias_bus.hit_port;
      end else begin
        next_st.xlat_reject = 1'b1;
      end
    end

    // receiver-detect fires on the rising edge of the qualified condition
    next_st.det_q = det_now;
    if (det_now && !st.det_q) begin
      next_st.rxdet_event = 1'b1;
      next_st.rxdet_irq = receiver_detect_irq_en && global_irq_en;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.phase <= PH_STRAP;
      st.cfg <= CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state flops, except enc_per_frame_inband, which is decoded from the cfg flops
  assign reg_rdata = st.rdata;
  assign reg_rvalid = st.rvalid;
  assign fwd_valid = st.fwd_valid;
  assign fwd_addr = st.fwd_addr;
  assign fwd_slot = st.fwd_slot;
  assign fwd_port = st.fwd_port;
  assign xlat_reject = st.xlat_reject;
  assign enhanced_link_check_en = st.cfg[CFG_ENH_BIT];
  assign repeater_enable = st.cfg[CFG_RPT_BIT];
  assign enc_mode = st.cfg[CFG_ENC_LSB +: 2];
  assign enc_per_frame_inband = st.cfg[CFG_ENC_LSB +: 2] == ENC_PER_FRAME_INBAND;
  assign receiver_detect_qualify = st.cfg[CFG_QUAL_BIT];
  assign rxdet_event = st.rxdet_event;
  assign rxdet_irq = st.rxdet_irq;
endmodule

/* File: tb/rlc_checker.sv */
/*
 * Concurrent checks on the ports of rlc_top.
 * Assumes one clock mclk and the active-low reset rstn.
 */
module rlc_checker
  import rlc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic xlat_req,
  input wire logic [6:0] xlat_addr,
  input wire logic [7:0][6:0] slave_id_table,
  input wire logic fwd_valid,
  input wire logic [6:0] fwd_addr,
  input wire logic [1:0] fwd_slot,
  input wire logic fwd_port,
  input wire logic xlat_reject,
  input wire logic frame_start,
  input wire logic link_check_strobe,
  input wire logic link_check_fail,
  input wire logic enhanced_link_check_en,
  input wire logic [1:0] enc_mode,
  input wire logic enc_per_frame_inband,
  input wire logic receiver_detect_qualify,
  input wire logic rx_detected,
  input wire logic rx_lock,
  input wire logic receiver_detect_irq_en,
  input wire logic global_irq_en,
  input wire logic rxdet_event,
  input wire logic rxdet_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // port relations
  // ************************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_RVALID: assert property (reg_rd |-> ##2 reg_rvalid)
    else $error("read answer missing");
  AST_CFG_RSVD: assert property (reg_rd && reg_addr == 8'hc2 |-> ##2 (reg_rdata & 8'h45) == 8'h00)
    else $error("config reserved bit set");
  AST_ALIAS_RSVD: assert property (reg_rd && reg_addr inside {[8'h7a:8'h7d]} |-> ##2 !reg_rdata[0])
    else $error("alias bit 0 set");
  AST_XLAT_ANS: assert property (xlat_req |-> ##2 (fwd_valid ^ xlat_reject))
    else $error("lookup answer wrong");
  AST_ZERO_REJECT: assert property (xlat_req && xlat_addr == 7'h00 |-> ##2 xlat_reject)
    else $error("zero address remapped");
  AST_FWD_ADDR: assert property (fwd_valid |-> fwd_addr == slave_id_table[{fwd_port, fwd_slot}])
    else $error("forward address wrong");
  AST_STROBE: assert property (link_check_strobe |-> $past(frame_start) && $past(enhanced_link_check_en))
    else $error("check strobe unexpected");
  AST_INBAND: assert property (enc_per_frame_inband == (enc_mode == 2'h3))
    else $error("in band flag wrong");
  AST_DET_RISE: assert property ($rose(rx_detected) && !receiver_detect_qualify |-> ##1 rxdet_event)
    else $error("detect event missing");
  AST_DET_QUAL: assert property (rxdet_event |-> $past(rx_detected) && ($past(rx_lock) || !$past(receiver_detect_qualify)))
    else $error("detect event unqualified");
  AST_IRQ: assert property (rxdet_irq |-> rxdet_event && $past(receiver_detect_irq_en) && $past(global_irq_en))
    else $error("detect irq not enabled");
  // main scenarios reached
  cover property (fwd_valid && fwd_port);
  cover property (link_check_strobe && link_check_fail);
  cover property (rxdet_irq);
endmodule

bind rlc_top rlc_checker i_rlc_checker (.mclk, .rstn, .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid, .xlat_req,
  .xlat_addr, .slave_id_table, .fwd_valid, .fwd_addr, .fwd_slot, .fwd_port, .xlat_reject, .frame_start,
  .link_check_strobe, .link_check_fail, .enhanced_link_check_en, .enc_mode, .enc_per_frame_inband,
  .receiver_detect_qualify, .rx_detected, .rx_lock, .receiver_detect_irq_en, .global_irq_en, .rxdet_event,
  .rxdet_irq);

/* File: tb/rlc_remote_model.sv */
/*
 * Remote deserializer seen from the block: slave ID table, receiver
 * presence and lock, and its check value. Assumes bench-driven commands.
 */
module rlc_remote_model
  import rlc_pkg::*;
(
  input wire logic det_cmd,
  input wire logic lock_cmd,
  output logic rx_detected,
  output logic rx_lock,
  output logic [7:0] remote_check_value,
  output logic [7:0][6:0] slave_id_table
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // remote side
  // ************************************************************
  // distinct ID per {port, slot} so a wrong slot shows up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      slave_id_table[i] = 7'h50 + 7'(i);
    end
  end
  // lock is only reported by a receiver that is present
  assign rx_detected = det_cmd;
  assign rx_lock = lock_cmd & det_cmd;
  assign remote_check_value = 8'h22;
endmodule

/* File: tb/rlc_top_test.sv */
/*
 * Self-checking bench for rlc_top through its register and lookup ports.
 * Assumes the remote model drives the far side inputs.
 */
module rlc_top_test
  import rlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rstn, repeater_strap, second_port_select, reg_wr, reg_rd, reg_rvalid, xlat_req, fwd_valid, fwd_port;
  logic xlat_reject, frame_start, link_check_strobe, link_check_fail, enhanced_link_check_en, repeater_enable;
  logic enc_per_frame_inband, receiver_detect_qualify, rx_detected, rx_lock, receiver_detect_irq_en;
  logic global_irq_en, rxdet_event, rxdet_irq, det_cmd, lock_cmd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cipher_check_value, remote_check_value;
  logic [6:0] xlat_addr, fwd_addr;
  logic [1:0] fwd_slot, enc_mode;
  logic [7:0][6:0] slave_id_table;
  int num_errors, total_checks, ev_n, irq_n, st_n;

  rlc_top i_rlc_top (.mclk, .rstn, .repeater_strap, .second_port_select, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .xlat_req, .xlat_addr, .slave_id_table, .fwd_valid, .fwd_addr,
    .fwd_slot, .fwd_port, .xlat_reject, .frame_start, .cipher_check_value, .remote_check_value,
    .link_check_strobe, .link_check_fail, .enhanced_link_check_en, .repeater_enable, .enc_mode,
    .enc_per_frame_inband, .receiver_detect_qualify, .rx_detected, .rx_lock, .receiver_detect_irq_en,
    .global_irq_en, .rxdet_event, .rxdet_irq);
  rlc_remote_model i_rlc_remote_model (.det_cmd, .lock_cmd, .rx_detected, .rx_lock, .remote_check_value,
    .slave_id_table);

  // ************************************************************
  // clock, event counters, tasks
  // ************************************************************
  always #2.5 mclk = ~mclk;
  // pulses are counted so short ones are never missed
  always @(posedge mclk) begin
    if (rxdet_event === 1'b1) ev_n++;
    if (rxdet_irq === 1'b1) irq_n++;
    if (link_check_strobe === 1'b1) st_n++;
  end
  function automatic logic [7:0] cfgo();
    return {enhanced_link_check_en, 1'b0, repeater_enable, enc_mode, 1'b0, receiver_detect_qualify, 1'b0};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    // the answer is launched at the second edge after the request and stands one cycle
    @(posedge mclk);
    #1;
    chk({7'h0, reg_rvalid}, 8'h01);
    chk(reg_rdata, e);
  endtask
  task automatic xl(input logic [6:0] a, input logic [2:0] ps, input logic hit);
    @(negedge mclk);
    xlat_addr = a;
    xlat_req = 1'b1;
    @(negedge mclk);
    xlat_req = 1'b0;
    @(posedge mclk);
    #1;
    chk({6'h0, fwd_valid, xlat_reject}, {6'h0, hit, !hit});
    if (hit) chk({fwd_port, fwd_slot, fwd_addr[4:0]}, {ps, 5'h10 + 5'(ps)});
  endtask
  // frame pulses with a gap, then time for the strobe to land
  task automatic fr(input int n);
    repeat (n) begin
      @(negedge mclk) frame_start = 1'b1;
      @(negedge mclk) frame_start = 1'b0;
    end
    repeat (3) @(negedge mclk);
  endtask
  task automatic rst(input logic s);
    @(negedge mclk) rstn = 1'b0;
    repeat (12) @(negedge mclk);
    repeater_strap = s;
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    #100us;
    num_errors++;
    test_done();
  end
  initial begin
    {rstn, repeater_strap, second_port_select, reg_wr, reg_rd, xlat_req, frame_start, det_cmd, lock_cmd} = '0;
    {reg_addr, reg_wdata, xlat_addr} = '0;
    {receiver_detect_irq_en, global_irq_en} = 2'b11;
    cipher_check_value = 8'h11;
    rst(1'b0);
    rd(8'h33, 8'h00);
    rd(8'hc2, 8'h80);
    chk(cfgo(), 8'h80);
    for (int i = 0; i < 4; i++) begin
      rd(8'h7a + 8'(i), 8'h00);
      wr(8'h7a + 8'(i), 8'h21 + 8'(i * 16));
      rd(8'h7a + 8'(i), 8'h20 + 8'(i * 16));
      xl(7'h10 + 7'(i * 8), 3'(i), 1'b1);
    end
    @(negedge mclk) second_port_select = 1'b1;
    rd(8'h7a, 8'h00);
    wr(8'h7a, 8'h31);
    xl(7'h18, 3'h4, 1'b1);
    @(negedge mclk) second_port_select = 1'b0;
    xl(7'h18, 3'h1, 1'b1);
    rd(8'h7a, 8'h20);
    wr(8'h7b, 8'h01);
    rd(8'h7b, 8'h00);
    xl(7'h18, 3'h0, 1'b0);
    xl(7'h00, 3'h0, 1'b0);
    for (int m = 0; m < 4; m++) begin
      logic [1:0] k;
      logic [7:0] v;
      k = 2'(m);
      v = {k[0], 1'b1, k[0], k, 1'b1, k[1], 1'b1};
      wr(8'hc2, v);
      rd(8'hc2, v & 8'hba);
      chk(cfgo(), v & 8'hba);
      chk({7'h0, enc_per_frame_inband}, {7'h0, k == 2'h3});
    end
    wr(8'hc2, 8'h00);
    wr(8'hc2, 8'h80);
    fr(15);
    chk(8'(st_n), 8'h00);
    fr(1);
    chk(8'(st_n), 8'h01);
    chk({7'h0, link_check_fail}, 8'h01);
    @(negedge mclk) cipher_check_value = 8'h22;
    fr(16);
    chk(8'(st_n), 8'h02);
    chk({7'h0, link_check_fail}, 8'h00);
    wr(8'hc2, 8'h00);
    fr(16);
    chk(8'(st_n), 8'h02);
    wr(8'hc2, 8'h80);
    @(negedge mclk) det_cmd = 1'b1;
    repeat (3) @(negedge mclk);
    chk(8'(ev_n), 8'h01);
    chk(8'(irq_n), 8'h01);
    det_cmd = 1'b0;
    wr(8'hc2, 8'h82);
    @(negedge mclk) det_cmd = 1'b1;
    repeat (3) @(negedge mclk);
    chk(8'(ev_n), 8'h01);
    lock_cmd = 1'b1;
    repeat (3) @(negedge mclk);
    chk(8'(ev_n), 8'h02);
    {det_cmd, lock_cmd, global_irq_en} = 3'b000;
    wr(8'hc2, 8'h80);
    @(negedge mclk) det_cmd = 1'b1;
    repeat (3) @(negedge mclk);
    chk(8'(ev_n), 8'h03);
    chk(8'(irq_n), 8'h02);
    rst(1'b1);
    rd(8'hc2, 8'h98);
    chk(cfgo(), 8'h98);
    test_done();
  end
endmodule
